/* logic/fll_clock_mode_controller.sv */
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fll_clock_mode_controller (
    input  wire logic                             mclk_i,
    input  wire logic                             sys_rst_i,
    input  wire logic                             mcu_reset_i,
    input  wire logic                             stop_i,
    input  wire logic                             debug_i,
    input  wire fll_clock_mode_pkg::det_pins_type pins_i,
    input  wire logic                             sample_i,
    input  wire logic [7:0]                       err_i,
    input  wire fll_clock_mode_pkg::reg_req_type  reg_req_i,
    output var  fll_clock_mode_pkg::gen_ctrl_type gen_ctrl_o,
    output var  fll_clock_mode_pkg::mode_type     actual_mode_o,
    output logic                                  lock_o,
    output logic [7:0]                            rd_data_o
);
    import fll_clock_mode_pkg::*;

    state_type state_q;
    state_type state_d;

    // Magnitude of a signed nine-bit value
    function automatic logic [8:0] mag(input logic [8:0] v);
        return v[8] ? 9'(-v) : v;
    endfunction : mag

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_type  n;
        logic [8:0] err_x;
        logic [9:0] avg_sum;
        logic       ref_rise;
        logic       wr_ctrl;
        logic       enter_off;
        n         = state_q;
        err_x     = {err_i[7], err_i};
        avg_sum   = 10'(state_q.avg_acc + {{2{err_i[7]}}, err_i});
        wr_ctrl   = reg_req_i.wr && (reg_req_i.addr == ADDR_CTRL);
        enter_off = stop_i && !debug_i && !state_q.off;

        // Detector pins: a level counts once stages two and three agree
        n.s1 = pins_i;
        n.s2 = state_q.s1;
        n.s3 = state_q.s2;
        for (int i = 0; i < 5; i++) begin
            if (state_q.s2[i] == state_q.s3[i]) begin
                n.pin[i] = state_q.s3[i];
            end
        end
        ref_rise = n.pin.ref_clk && !state_q.pin.ref_clk;

        // Register reads, data stands one cycle later
        n.rd_data = 8'h00;
        if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                ADDR_CTRL:   n.rd_data = {1'b0, state_q.multiplication_factor, state_q.keep, state_q.reference_type_select, state_q.req};
                ADDR_DIV:    n.rd_data = {5'h00, state_q.rfd};
                ADDR_STAT:   n.rd_data = {state_q.ext_ready, state_q.dco_stable_flag, state_q.pin.ext_ref_valid,
                                          state_q.loss_of_clock_flag, state_q.lol, state_q.lock, state_q.mode};
                ADDR_FLT_HI: n.rd_data = {4'h0, state_q.filter[11:8]};
                ADDR_FLT_LO: n.rd_data = state_q.filter[7:0];
                ADDR_TRIM:   n.rd_data = state_q.trim;
                default:     n.rd_data = 8'h00;
            endcase
        end

        // Register writes; a changed mode request or multiplier is an expected unlock
        if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                ADDR_CTRL: begin
                    n.req  = reg_req_i.wdata[1:0];
                    n.reference_type_select = reg_req_i.wdata[CTRL_REFERENCE_TYPE_SELECT_BIT];
                    n.keep = reg_req_i.wdata[CTRL_KEEP_BIT];
                    n.multiplication_factor  = reg_req_i.wdata[CTRL_MFD_LSB +: 3];
                    if (n.req != state_q.req || n.multiplication_factor != state_q.multiplication_factor) begin
                        n.lock     = 1'b0;
                        n.lock_cnt = 3'h0;
                    end
                end
                ADDR_DIV: n.rfd = reg_req_i.wdata[2:0];
                ADDR_STAT: begin
                    if (reg_req_i.wdata[STAT_LOL_BIT]) begin
                        n.lol = 1'b0;
                    end
                    if (reg_req_i.wdata[STAT_LOC_BIT]) begin
                        n.loss_of_clock_flag = 1'b0;
                    end
                end
                ADDR_FLT_LO: begin
                    if (state_q.mode == MODE_SCM && state_q.req == 2'b00) begin
                        n.flt_lo = reg_req_i.wdata;
                    end
                end
                ADDR_FLT_HI: begin
                    if (state_q.mode == MODE_SCM && state_q.req == 2'b00) begin
                        n.filter = {reg_req_i.wdata[3:0], state_q.flt_lo};
                    end
                end
                ADDR_TRIM: begin
                    n.trim = reg_req_i.wdata;
                    if (state_q.mode == MODE_FEI) begin
                        n.lock     = 1'b0;
                        n.lock_cnt = 3'h0;
                    end
                end
                default: ;
            endcase
        end

        // Loss of clock is sticky; a new loss beats a clear in the same cycle
        if (state_q.pin.ref_lost || state_q.pin.dco_lost) begin
            n.loss_of_clock_flag = 1'b1;
        end

        // DCO stability: two steady samples in a row and a moving DCO
        if (sample_i && state_q.ctrl.dco_en) begin
            n.prev_err = err_i;
            if (mag(9'(err_x - {state_q.prev_err[7], state_q.prev_err})) <= UNLOCK_N) begin
                if (state_q.stable_cnt != STABLE_SAMPLES) begin
                    n.stable_cnt = 2'(state_q.stable_cnt + 2'h1);
                end
            end else begin
                n.stable_cnt = 2'h0;
            end
        end
        n.dco_stable_flag = (n.stable_cnt == STABLE_SAMPLES) && state_q.pin.dco_active;

        // Stop handling; the exit path depends on settings seen at entry
        if (enter_off) begin
            n.off         = 1'b1;
            n.fbe_on_exit = (state_q.req == 2'b10) && state_q.pin.ext_ref_valid;
            n.dco_stable_flag        = 1'b0;
            n.stable_cnt  = 2'h0;
            n.lock        = 1'b0;
            n.lock_cnt    = 3'h0;
        end else if (state_q.off && !stop_i) begin
            n.off = 1'b0;
            if (state_q.fbe_on_exit) begin
                n.mode = MODE_FBE;
            end else begin
                n.mode       = MODE_SCM;
                n.auto_close = state_q.req[0];
            end
        end else if (!state_q.off) begin
            if (wr_ctrl && n.req == 2'b00) begin
                n.mode       = MODE_SCM;
                n.auto_close = 1'b0;
            end else if (wr_ctrl && n.req == 2'b01) begin
                n.mode       = MODE_FEI;
                n.auto_close = 1'b0;
            end else begin
                unique case (state_q.mode)
                    MODE_SCM: begin
                        if (state_q.auto_close && state_q.dco_stable_flag) begin
                            n.mode       = state_q.req[1] ? MODE_FEE : MODE_FEI;
                            n.auto_close = 1'b0;
                        end else if (state_q.req == 2'b10 && state_q.pin.ext_ref_valid) begin
                            n.mode = MODE_FBE;
                        end else if (state_q.req == 2'b11 && state_q.pin.ext_ref_valid && state_q.dco_stable_flag) begin
                            n.mode = MODE_FEE;
                        end
                    end
                    MODE_FEI: begin
                        if (state_q.req == 2'b11 && state_q.pin.ext_ref_valid && state_q.dco_stable_flag) begin
                            n.mode = MODE_FEE;
                        end
                    end
                    MODE_FEE: begin
                        if (state_q.pin.ref_lost || (!state_q.pin.ext_ref_valid && state_q.loss_of_clock_flag)) begin
                            n.mode = MODE_SCM;
                            n.req  = 2'b00;
                        end else if (state_q.pin.dco_lost && state_q.pin.ext_ref_valid) begin
                            n.mode = MODE_FBE;
                            n.req  = 2'b10;
                        end
                    end
                    MODE_FBE: begin
                        if (state_q.pin.ref_lost || (!state_q.pin.ext_ref_valid && state_q.loss_of_clock_flag)) begin
                            n.mode = MODE_SCM;
                            n.req  = 2'b00;
                        end
                    end
                endcase
            end
        end

        // A change of mode restarts lock acquisition without flagging a loss
        if (n.mode != state_q.mode) begin
            n.lock     = 1'b0;
            n.lock_cnt = 3'h0;
            n.avg_cnt  = 2'h0;
            n.avg_acc  = 10'h000;
            if (n.mode == MODE_FEE) begin
                n.first_lock = 1'b0;
            end
        end else if (sample_i && !state_q.off && state_q.mode[0]) begin
            // Closed loop: LOCKED_INTERNAL_REF_MODE or FEE steering the DCO toward the multiplier
            if (!state_q.lock) begin
                n.filter = 12'(state_q.filter - {{3{err_x[8]}}, err_x});
                if (mag(err_x) <= LOCK_N) begin
                    n.lock_cnt = 3'(state_q.lock_cnt + 3'h1);
                    if (state_q.lock_cnt == LOCK_SAMPLES - 3'h1) begin
                        n.lock       = 1'b1;
                        n.first_lock = 1'b1;
                        n.avg_cnt    = 2'h0;
                        n.avg_acc    = 10'h000;
                    end
                end else begin
                    n.lock_cnt = 3'h0;
                end
            end else if (mag(err_x) > UNLOCK_N) begin
                n.lock     = 1'b0;
                n.lol      = 1'b1;
                n.lock_cnt = 3'h0;
            end else begin
                // Averaging trades response speed for less DCO jitter when locked
                n.avg_cnt = 2'(state_q.avg_cnt + 2'h1);
                n.avg_acc = avg_sum;
                if (state_q.avg_cnt == AVG_LAST) begin
                    n.filter  = 12'(state_q.filter - {{4{avg_sum[9]}}, avg_sum[9:2]});
                    n.avg_acc = 10'h000;
                end
            end
        end

        // Crystal start-up: count reference edges before trusting the source
        if (!state_q.ctrl.osc_en) begin
            n.xtal_cnt  = 13'h0000;
            n.ext_ready = 1'b0;
        end else if (!state_q.reference_type_select) begin
            n.ext_ready = state_q.pin.ext_ref_valid;
        end else if (ref_rise && !state_q.ext_ready) begin
            n.xtal_cnt = 13'(state_q.xtal_cnt + 13'h0001);
            if (n.xtal_cnt == XTAL_COUNT) begin
                n.ext_ready = 1'b1;
            end
        end

        // Warm reset discards everything but trim and the synchronisers
        if (mcu_reset_i) begin
            n      = rst_state(state_q.trim);
            n.s1   = pins_i;
            n.s2   = state_q.s1;
            n.s3   = state_q.s2;
            n.pin  = state_q.pin;
        end

        // Generator controls follow the settled next state
        n.ctrl.period   = PERIOD_BASE + {2'b00, n.trim};
        n.ctrl.filter   = n.filter;
        n.ctrl.multiplication_factor      = n.multiplication_factor;
        n.ctrl.dco_en   = (n.mode != MODE_FBE) && (!n.off || n.keep);
        n.ctrl.irg_en   = (n.mode != MODE_FBE) && (!n.off || n.keep);
        n.ctrl.osc_en   = n.req[1] && (!n.off || n.keep);
        n.ctrl.loop_closed  = n.mode[0] && !n.off;
        n.ctrl.loop_ref_ext = (n.mode == MODE_FEE) && n.ext_ready;
        n.ctrl.src_ext  = (n.mode == MODE_FBE);
        n.ctrl.feed     = !n.off && !((n.mode == MODE_FBE) && !n.ext_ready);
        n.ctrl.div_log2 = {1'b0, n.rfd} + {3'h0, (n.mode == MODE_FEE) && !n.first_lock};
        state_d = n;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= rst_state(TRIM_POR);
        end else begin
            state_q <= state_d;
        end
    end

    // Every output comes straight from the state register
    assign gen_ctrl_o    = state_q.ctrl;
    assign actual_mode_o = state_q.mode;
    assign lock_o        = state_q.lock;
    assign rd_data_o     = state_q.rd_data;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    trim_period_a: assert property (
        reg_req_i.wr && reg_req_i.addr == ADDR_TRIM && !mcu_reset_i
        |=> gen_ctrl_o.period == PERIOD_BASE + {2'b00, $past(reg_req_i.wdata)})
        else $error("reference period does not follow trim");

    stop_off_a: assert property (
        stop_i && !debug_i && !state_q.off && !state_q.keep && !mcu_reset_i
        |=> state_q.off && !gen_ctrl_o.feed && !gen_ctrl_o.dco_en && !gen_ctrl_o.osc_en)
        else $error("clocks still active in stop");

    debug_run_a: assert property (
        stop_i && debug_i && !state_q.off |=> !state_q.off)
        else $error("debug stop entered off state");

    keep_osc_a: assert property (
        state_q.off && state_q.keep && state_q.mode != MODE_FBE
        |-> gen_ctrl_o.dco_en && !gen_ctrl_o.feed)
        else $error("keep option wrong during stop");

    warm_reset_a: assert property (
        mcu_reset_i && !(reg_req_i.wr && reg_req_i.addr == ADDR_TRIM)
        |=> state_q.mode == MODE_SCM && state_q.req == 2'b00 && $stable(state_q.trim))
        else $error("warm reset did not restore defaults");

    xtal_ready_a: assert property (
        $rose(state_q.ext_ready) && state_q.reference_type_select |-> state_q.xtal_cnt == XTAL_COUNT)
        else $error("crystal ready before full count");

    flt_guard_a: assert property (
        reg_req_i.wr && reg_req_i.addr == ADDR_FLT_HI && state_q.mode != MODE_SCM
        && !sample_i && !mcu_reset_i |=> $stable(state_q.filter))
        else $error("filter written outside self-clocked mode");

    lol_sticky_a: assert property (
        state_q.lol && !mcu_reset_i && !(reg_req_i.wr && reg_req_i.addr == ADDR_STAT
        && reg_req_i.wdata[STAT_LOL_BIT]) |=> state_q.lol)
        else $error("loss of lock flag dropped");

    fee_div_a: assert property (
        state_q.mode == MODE_FEE && !state_q.first_lock
        |-> gen_ctrl_o.div_log2 == {1'b0, state_q.rfd} + 4'h1)
        else $error("initial external divider not doubled");

    fbe_hold_a: assert property (
        state_q.mode == MODE_FBE && !state_q.ext_ready |-> !gen_ctrl_o.feed)
        else $error("bypass output enabled before reference ready");

endmodule : fll_clock_mode_controller
`default_nettype wire

/* logic/fll_clock_mode_pkg.sv */
package fll_clock_mode_pkg;

    // ----------------------------------------
    // Register map and field positions
    // ----------------------------------------
    localparam logic [2:0] ADDR_CTRL   = 3'h0;
    localparam logic [2:0] ADDR_DIV    = 3'h1;
    localparam logic [2:0] ADDR_STAT   = 3'h2;
    localparam logic [2:0] ADDR_FLT_HI = 3'h3;
    localparam logic [2:0] ADDR_FLT_LO = 3'h4;
    localparam logic [2:0] ADDR_TRIM   = 3'h5;
    localparam int         CTRL_REFERENCE_TYPE_SELECT_BIT = 2;
    localparam int         CTRL_KEEP_BIT = 3;
    localparam int         CTRL_MFD_LSB  = 4;
    localparam int         STAT_LOCK_BIT = 2;
    localparam int         STAT_LOL_BIT  = 3;
    localparam int         STAT_LOC_BIT  = 4;
    localparam int         STAT_ERC_BIT  = 5;
    localparam int         STAT_DCO_BIT  = 6;
    localparam int         STAT_RDY_BIT  = 7;

    // ----------------------------------------
    // Reset values and counts
    // ----------------------------------------
    localparam logic [7:0]  TRIM_POR       = 8'h80;
    localparam logic [9:0]  PERIOD_BASE    = 10'h180;
    localparam logic [11:0] FILTER_RST     = 12'h000;
    localparam logic [2:0]  MFD_RST        = 3'h0;
    localparam logic [2:0]  RFD_RST        = 3'h0;
    localparam logic [8:0]  LOCK_N         = 9'h004;
    localparam logic [8:0]  UNLOCK_N       = 9'h008;
    localparam logic [2:0]  LOCK_SAMPLES   = 3'h4;
    localparam logic [1:0]  STABLE_SAMPLES = 2'h2;
    localparam logic [1:0]  AVG_LAST       = 2'h3;
    localparam logic [12:0] XTAL_COUNT     = 13'h1000;

    typedef enum logic [1:0] {
        MODE_SCM = 2'b00,
        MODE_FEI = 2'b01,
        MODE_FEE = 2'b11,
        MODE_FBE = 2'b10
    } mode_type;

    typedef struct packed {
        logic ref_clk;
        logic ext_ref_valid;
        logic ref_lost;
        logic dco_lost;
        logic dco_active;
    } det_pins_type;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic        feed;
        logic        dco_en;
        logic        irg_en;
        logic        osc_en;
        logic        loop_closed;
        logic        loop_ref_ext;
        logic        src_ext;
        logic [3:0]  div_log2;
        logic [9:0]  period;
        logic [11:0] filter;
        logic [2:0]  multiplication_factor;
    } gen_ctrl_type;

    typedef struct packed {
        det_pins_type s1;
        det_pins_type s2;
        det_pins_type s3;
        det_pins_type pin;
        mode_type     mode;
        logic         off;
        logic         fbe_on_exit;
        logic         auto_close;
        logic [1:0]   req;
        logic         reference_type_select;
        logic         keep;
        logic [2:0]   multiplication_factor;
        logic [2:0]   rfd;
        logic [7:0]   trim;
        logic [11:0]  filter;
        logic [7:0]   flt_lo;
        logic         lock;
        logic         lol;
        logic         loss_of_clock_flag;
        logic         first_lock;
        logic [2:0]   lock_cnt;
        logic [1:0]   avg_cnt;
        logic [9:0]   avg_acc;
        logic [7:0]   prev_err;
        logic [1:0]   stable_cnt;
        logic         dco_stable_flag;
        logic [12:0]  xtal_cnt;
        logic         ext_ready;
        gen_ctrl_type ctrl;
        logic [7:0]   rd_data;
    } state_type;

    // Defaults after any reset; trim is handed in so a warm reset can keep it
    function automatic state_type rst_state(input logic [7:0] trim);
        state_type s;
        s        = '0;
        s.mode   = MODE_SCM;
        s.multiplication_factor    = MFD_RST;
        s.rfd    = RFD_RST;
        s.trim   = trim;
        s.filter = FILTER_RST;
        s.ctrl.dco_en = 1'b1;
        s.ctrl.irg_en = 1'b1;
        s.ctrl.feed   = 1'b1;
        s.ctrl.period = PERIOD_BASE + {2'b00, trim};
        s.ctrl.filter = FILTER_RST;
        s.ctrl.multiplication_factor    = MFD_RST;
        return s;
    endfunction : rst_state

endpackage : fll_clock_mode_pkg

/* sim/ext_ref_source.sv */
`timescale 1ns/1ps
`default_nettype none
// Reference source as the controller sees it through its detector pins
module ext_ref_source (
    input  wire logic                             valid_i,
    output var  fll_clock_mode_pkg::det_pins_type pins_o
);
    import fll_clock_mode_pkg::*;
    logic ref_clk = 1'b0;
    // 50 ns half period: 10 MHz, the fastest reference allowed for locked use
    always #50 ref_clk = ~ref_clk;
    // No losses reported; the DCO stays active so stability can be judged
    assign pins_o = '{ref_clk: ref_clk, ext_ref_valid: valid_i, ref_lost: 1'b0, dco_lost: 1'b0,
                      dco_active: 1'b1};
endmodule : ext_ref_source
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fll_clock_mode_pkg::*;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic         mclk_i      = 1'b0;
    logic         sys_rst_i   = 1'b1;
    logic         mcu_reset_i = 1'b0;
    logic         stop_i      = 1'b0;
    logic         debug_i     = 1'b0;
    logic         sample_i    = 1'b0;
    logic [7:0]   err_i       = 8'h00;
    logic         ref_valid   = 1'b0;
    reg_req_type  reg_req_i   = '0;
    det_pins_type pins_i;
    gen_ctrl_type gen_ctrl_o;
    mode_type     actual_mode_o;
    logic         lock_o;
    logic [7:0]   rd_data_o;
    logic [7:0]   rv;
    int           n_errors    = 0;
    int           checks      = 0;

    always #12.5 mclk_i = ~mclk_i;

    fll_clock_mode_controller i_fll_clock_mode_controller (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .mcu_reset_i(mcu_reset_i), .stop_i(stop_i), .debug_i(debug_i), .pins_i(pins_i),
        .sample_i(sample_i), .err_i(err_i), .reg_req_i(reg_req_i), .gen_ctrl_o(gen_ctrl_o),
        .actual_mode_o(actual_mode_o), .lock_o(lock_o), .rd_data_o(rd_data_o));
    ext_ref_source i_ext_ref_source (.valid_i(ref_valid), .pins_o(pins_i));

    // ----------------------------------------
    // Shared bus, sample and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Writes settle for two cycles so mode changes have landed before checks
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_req_i <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge mclk_i);
        reg_req_i <= '0;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        reg_req_i <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge mclk_i);
        reg_req_i <= '0;
        #1 d = rd_data_o;
    endtask : rd
    task automatic smp(input logic [7:0] e, input int n);
        repeat (n) begin
            @(posedge mclk_i);
            sample_i <= 1'b1;
            err_i    <= e;
            @(posedge mclk_i);
            sample_i <= 1'b0;
        end
        repeat (2) @(posedge mclk_i);
        #1;
    endtask : smp
    // Mode changes pass pin synchronisers, so allow a bounded wait
    task automatic wait_mode(input mode_type m);
        int n;
        n = 0;
        while (actual_mode_o !== m && n < 40) begin
            @(posedge mclk_i);
            n++;
        end
        #1 chk(actual_mode_o, m);
    endtask : wait_mode

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_trim_reset();
        chk(actual_mode_o, MODE_SCM);
        chk(gen_ctrl_o.period, 12'h200);
        rd(ADDR_TRIM, rv);
        chk(rv, 8'h80);
        wr(ADDR_TRIM, 8'hc0);
        chk(gen_ctrl_o.period, 12'h240);
        wr(ADDR_TRIM, 8'h40);
        wr(ADDR_CTRL, 8'h01);
        @(posedge mclk_i);
        mcu_reset_i <= 1'b1;
        @(posedge mclk_i);
        mcu_reset_i <= 1'b0;
        wait_mode(MODE_SCM);
        chk(gen_ctrl_o.period, 12'h1c0);
    endtask : t_trim_reset
    task automatic t_filter_lock();
        wr(ADDR_FLT_LO, 8'h34);
        wr(ADDR_FLT_HI, 8'h02);
        chk(gen_ctrl_o.filter, 12'h234);
        wr(ADDR_CTRL, 8'h01);
        wait_mode(MODE_FEI);
        chk(gen_ctrl_o.loop_closed, 1'b1);
        wr(ADDR_FLT_LO, 8'h55);
        wr(ADDR_FLT_HI, 8'h03);
        chk(gen_ctrl_o.filter, 12'h234);
        smp(8'h00, 3);
        chk(lock_o, 1'b0);
        smp(8'h00, 1);
        chk(lock_o, 1'b1);
        smp(8'h04, 4);
        chk(gen_ctrl_o.filter, 12'h230);
        smp(8'h14, 1);
        chk(lock_o, 1'b0);
        rd(ADDR_STAT, rv);
        chk(rv[STAT_LOL_BIT], 1'b1);
        wr(ADDR_CTRL, 8'h00);
        wait_mode(MODE_SCM);
    endtask : t_filter_lock
    // Level inputs change only by non-blocking assignment on a rising edge
    task automatic t_stop_bypass();
        @(posedge mclk_i);
        stop_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1 chk(gen_ctrl_o.feed, 1'b0);
        @(posedge mclk_i);
        stop_i <= 1'b0;
        // Leaving off takes one edge, and the feed flop rises on that same edge
        repeat (2) @(posedge mclk_i);
        wait_mode(MODE_SCM);
        chk(gen_ctrl_o.feed, 1'b1);
        @(posedge mclk_i);
        debug_i <= 1'b1;
        stop_i  <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1 chk(gen_ctrl_o.feed, 1'b1);
        @(posedge mclk_i);
        stop_i  <= 1'b0;
        debug_i <= 1'b0;
        ref_valid <= 1'b1;
        wr(ADDR_CTRL, 8'h02);
        wait_mode(MODE_FBE);
        chk({gen_ctrl_o.dco_en, gen_ctrl_o.irg_en, gen_ctrl_o.src_ext}, 12'h001);
    endtask : t_stop_bypass

    task automatic summarize();
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (6) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        #1;
        t_trim_reset();
        t_filter_lock();
        t_stop_bypass();
        summarize();
    end
    // Whole run needs well under 10 us
    initial begin
        #100000;
        n_errors++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
